// File: line_alarm_pkg.sv
// constants of the receive line alarm detector: register map, fields, timing
// assumes one 10 MHz clock, registers on a 32-bit bus, one word per register
package line_alarm_pkg;

    // -------------------------------------------------------------------
    // register indices, byte address is four times the index
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_FRAMER_MODE_FIRST = 8'h1c;
    localparam logic [7:0] IDX_LINE_INTERFACE_MODE_ONE = 8'h35;
    localparam logic [7:0] IDX_TRANSITION_WINDOW_COUNT = 8'h36;
    localparam logic [7:0] IDX_RECOVERY_PULSE_COUNT = 8'h37;
    localparam logic [7:0] IDX_FRAMER_RECEIVE_STATUS_FIRST = 8'h4c;
    localparam logic [7:0] IDX_INTERRUPT_STATUS_TWO = 8'h6a;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int ALARM_EMULATION_BIT_POS = 0;
    localparam int ALARM_CRITERION_SELECT_POS = 1;
    localparam int DUAL_RAIL_SELECT_POS = 0;
    localparam int INPUT_THRESHOLD_SELECT_LSB = 4;
    localparam int STATUS_SIGNAL_ABSENT_POS = 7;
    localparam int STATUS_ALARM_INDICATION_POS = 6;
    localparam int INT_SIGNAL_ABSENT_POS = 0;
    localparam int INT_ALARM_INDICATION_POS = 1;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RESET_REG_BYTE = 8'h00;

    // -------------------------------------------------------------------
    // timing and counts
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int AIS_WINDOW_US = 250;
    localparam int AIS_WINDOW_CYCLES = (AIS_WINDOW_US * 1000) / CLK_PERIOD_NS;
    localparam int DOUBLEFRAME_BITS = 512;
    localparam int WINDOW_GRANULE = 16;
    localparam logic [1:0] FEW_ZEROS_MAX = 2'h2;

    // receive level thresholds, level units of 10 mV
    localparam logic [7:0] THRESHOLD_TABLE [8] = '{
        8'h68, 8'h54, 8'h3e, 8'h2b, 8'h20, 8'h16, 8'h10, 8'hff
    };

endpackage

// File: line_input_sync.sv
// three-stage input filter for pins from outside the clock domain
// assumes pins change slowly against clk_in; value taken when stages 2 and 3 agree
`timescale 1ns/1ps
module line_input_sync
    import line_alarm_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // pins and filtered values
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] value_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire [WIDTH-1:0] next_value = (stage2 & agree) | (value_out & ~agree);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            value_out <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            value_out <= next_value;
        end
    end
endmodule // line_input_sync

// File: zero_window_counter.sv
// counts zeros over a fixed window of steps and reports a sparse-zero window
// assumes step_in and zero_in are on clk_in; a zero may coincide with the last step
`timescale 1ns/1ps
module zero_window_counter
    import line_alarm_pkg::*;
#(
    parameter int LEN = 512,
    parameter int POS_W = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // window input
    input wire logic step_in,
    input wire logic zero_in,
    // window result
    output logic done_out,
    output logic few_zeros_out
);
    localparam logic [POS_W-1:0] LAST_POS = POS_W'(LEN - 1);
    logic [POS_W-1:0] pos;
    logic [1:0] zeros;
    wire [1:0] next_zeros = (zero_in && zeros != 2'h3) ? zeros + 2'h1 : zeros;
    wire window_end = step_in && pos == LAST_POS;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pos <= '0;
            zeros <= 2'h0;
            done_out <= 1'b0;
            few_zeros_out <= 1'b0;
        end else begin
            done_out <= window_end;
            if (window_end) begin
                pos <= '0;
                zeros <= 2'h0;
                few_zeros_out <= next_zeros <= FEW_ZEROS_MAX;
            end else begin
                pos <= step_in ? pos + POS_W'(1) : pos;
                zeros <= next_zeros;
            end
        end
    end
endmodule // zero_window_counter

// File: line_alarm_detector.sv
// receive line alarm detector: signal-absent and alarm-indication detection
// assumes line pins asynchronous to clk_in, framer flags on clk_in, AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module line_alarm_detector
    import line_alarm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // receive line pins
    input wire logic rx_line_clock_in,
    input wire logic rx_pos_rail_in,
    input wire logic rx_neg_rail_in,
    input wire logic [7:0] rx_level_in,
    // framer status on clk_in
    input wire logic frame_sync_lost_in,
    input wire logic frame_alignment_word_in,
    // alarm flags
    output logic signal_absent_flag_out,
    output logic alarm_indication_flag_out
);
    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    logic [7:0] framer_mode_first;
    logic [7:0] line_interface_mode_one;
    logic [7:0] transition_window_count;
    logic [7:0] recovery_pulse_count;
    logic [7:0] interrupt_status_two;

    // -------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------
    wire bus_take = hsel_in && htrans_in[1] && hready_in;
    wire [7:0] take_idx = haddr_in[9:2];
    wire take_read = bus_take && !hwrite_in;
    logic wr_pending;
    logic [7:0] wr_idx;
    wire [7:0] wr_byte = hwdata_in[7:0];
    wire wr_fmr = wr_pending && wr_idx == IDX_FRAMER_MODE_FIRST;
    wire wr_lim = wr_pending && wr_idx == IDX_LINE_INTERFACE_MODE_ONE;
    wire wr_pcd = wr_pending && wr_idx == IDX_TRANSITION_WINDOW_COUNT;
    wire wr_pcr = wr_pending && wr_idx == IDX_RECOVERY_PULSE_COUNT;
    wire rd_isr = take_read && take_idx == IDX_INTERRUPT_STATUS_TWO;
    wire [7:0] status_byte;
    wire [7:0] read_byte =
        (take_idx == IDX_FRAMER_MODE_FIRST) ? framer_mode_first :
        (take_idx == IDX_LINE_INTERFACE_MODE_ONE) ? line_interface_mode_one :
        (take_idx == IDX_TRANSITION_WINDOW_COUNT) ? transition_window_count :
        (take_idx == IDX_RECOVERY_PULSE_COUNT) ? recovery_pulse_count :
        (take_idx == IDX_FRAMER_RECEIVE_STATUS_FIRST) ? status_byte :
        (take_idx == IDX_INTERRUPT_STATUS_TWO) ? interrupt_status_two : 8'h00;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_pending <= 1'b0;
            wr_idx <= 8'h00;
            hrdata_out <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            wr_pending <= bus_take && hwrite_in;
            wr_idx <= take_idx;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (take_read) begin
                hrdata_out <= {24'h000000, read_byte};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            framer_mode_first <= RESET_REG_BYTE;
            line_interface_mode_one <= RESET_REG_BYTE;
            transition_window_count <= RESET_REG_BYTE;
            recovery_pulse_count <= RESET_REG_BYTE;
        end else begin
            if (wr_fmr) framer_mode_first <= wr_byte;
            if (wr_lim) line_interface_mode_one <= wr_byte;
            if (wr_pcd) transition_window_count <= wr_byte;
            if (wr_pcr) recovery_pulse_count <= wr_byte;
        end
    end

    // -------------------------------------------------------------------
    // control fields
    // -------------------------------------------------------------------
    wire emulation = framer_mode_first[ALARM_EMULATION_BIT_POS];
    wire criterion = framer_mode_first[ALARM_CRITERION_SELECT_POS];
    wire dual_rail = line_interface_mode_one[DUAL_RAIL_SELECT_POS];
    wire [2:0] threshold_sel =
        line_interface_mode_one[INPUT_THRESHOLD_SELECT_LSB +: 3];
    // T = 16 * (N + 1), 16 to 4096
    wire [12:0] window_len = {1'b0, transition_window_count, 4'h0}
        + 13'(WINDOW_GRANULE);
    wire [8:0] needed_pulses = {1'b0, recovery_pulse_count} + 9'h001;

    // -------------------------------------------------------------------
    // line sampling
    // -------------------------------------------------------------------
    wire [10:0] line_f;
    line_input_sync #(
        .WIDTH(11)
    ) u_line_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in({rx_line_clock_in, rx_pos_rail_in, rx_neg_rail_in, rx_level_in}),
        .value_out(line_f)
    );
    logic line_clock_prev;
    always_ff @(posedge clk_in) begin
        if (srst_in) line_clock_prev <= 1'b0;
        else line_clock_prev <= line_f[10];
    end
    // one pulse position per receive clock rising edge
    wire bit_tick = line_f[10] && !line_clock_prev;
    wire above_level = line_f[7:0] > THRESHOLD_TABLE[threshold_sel];
    wire pulse_seen = dual_rail ? (line_f[9] | line_f[8]) : above_level;
    wire pulse_at_tick = bit_tick && pulse_seen;
    wire zero_at_tick = bit_tick && !pulse_seen;

    // -------------------------------------------------------------------
    // signal absent detection and recovery
    // -------------------------------------------------------------------
    logic [12:0] quiet_count;
    logic los_real;
    logic win_active;
    logic [12:0] win_pos;
    logic [8:0] win_pulses;
    wire quiet_full = quiet_count + 13'h0001 >= window_len;
    wire win_over = win_pos + 13'h0001 >= window_len;
    wire recovered = {4'h0, win_pulses} + 13'h0001 >= {4'h0, needed_pulses};

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            quiet_count <= 13'h0000;
            los_real <= 1'b0;
            win_active <= 1'b0;
            win_pos <= 13'h0000;
            win_pulses <= 9'h000;
        end else if (bit_tick) begin
            quiet_count <= pulse_seen ? 13'h0000 : quiet_count + 13'h0001;
            if (!los_real) begin
                win_active <= 1'b0;
                if (!pulse_seen && quiet_full) los_real <= 1'b1;
            end else if (pulse_seen && (!win_active || win_over)) begin
                // a pulse on the position just past an old window opens the next one
                win_active <= 1'b1;
                win_pos <= 13'h0000;
                win_pulses <= 9'h001;
                if (needed_pulses == 9'h001) los_real <= 1'b0;
            end else if (win_active && win_over) begin
                // window ran out, the next pulse reopens it
                win_active <= 1'b0;
            end else if (pulse_seen) begin
                if (recovered) begin
                    los_real <= 1'b0;
                end else begin
                    win_pulses <= win_pulses + 9'h001;
                    win_pos <= win_pos + 13'h0001;
                end
            end else if (win_active) begin
                win_pos <= win_pos + 13'h0001;
            end
        end
    end

    // -------------------------------------------------------------------
    // alarm indication detection
    // -------------------------------------------------------------------
    wire time_done;
    wire time_few;
    wire frame_done;
    wire frame_few;
    zero_window_counter #(
        .LEN(AIS_WINDOW_CYCLES),
        .POS_W(12)
    ) u_time_window (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .step_in(1'b1),
        .zero_in(zero_at_tick),
        .done_out(time_done),
        .few_zeros_out(time_few)
    );
    zero_window_counter #(
        .LEN(DOUBLEFRAME_BITS),
        .POS_W(10)
    ) u_frame_window (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .step_in(bit_tick),
        .zero_in(zero_at_tick),
        .done_out(frame_done),
        .few_zeros_out(frame_few)
    );

    logic ais_time;
    logic ais_frame;
    logic frame_few_prev;
    logic frame_seen_one;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ais_time <= 1'b0;
            ais_frame <= 1'b0;
            frame_few_prev <= 1'b0;
            frame_seen_one <= 1'b0;
        end else begin
            if (time_done) begin
                ais_time <= time_few && frame_sync_lost_in;
            end
            if (frame_done) begin
                frame_seen_one <= 1'b1;
                frame_few_prev <= frame_few;
            end
            if (frame_alignment_word_in) begin
                ais_frame <= 1'b0;
            end else if (frame_done && frame_seen_one) begin
                if (frame_few && frame_few_prev) ais_frame <= 1'b1;
                else if (!frame_few && !frame_few_prev) ais_frame <= 1'b0;
            end
        end
    end
    wire ais_real = criterion ? ais_frame : ais_time;

    // -------------------------------------------------------------------
    // flags, status and interrupt status
    // -------------------------------------------------------------------
    wire next_los_flag = los_real || emulation;
    wire next_ais_flag = ais_real || emulation;
    wire los_rise = next_los_flag && !signal_absent_flag_out;
    wire ais_rise = next_ais_flag && !alarm_indication_flag_out;
    wire [7:0] isr_set = (8'(los_rise) << INT_SIGNAL_ABSENT_POS)
        | (8'(ais_rise) << INT_ALARM_INDICATION_POS);
    // clear on read loses to a set in the same cycle
    wire [7:0] next_isr = (rd_isr ? 8'h00 : interrupt_status_two) | isr_set;
    assign status_byte = (8'(signal_absent_flag_out) << STATUS_SIGNAL_ABSENT_POS)
        | (8'(alarm_indication_flag_out) << STATUS_ALARM_INDICATION_POS);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            signal_absent_flag_out <= 1'b0;
            alarm_indication_flag_out <= 1'b0;
            interrupt_status_two <= RESET_REG_BYTE;
        end else begin
            signal_absent_flag_out <= next_los_flag;
            alarm_indication_flag_out <= next_ais_flag;
            interrupt_status_two <= next_isr;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    AST_EMU_FORCE: assert property (@(posedge clk_in) disable iff (srst_in)
        emulation |=> signal_absent_flag_out && alarm_indication_flag_out)
        else $error("emulation did not force both flags");
    AST_LOS_INT: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(signal_absent_flag_out) |-> interrupt_status_two[INT_SIGNAL_ABSENT_POS])
        else $error("signal absent rise did not set interrupt status");
    AST_AIS_INT: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(alarm_indication_flag_out) |-> interrupt_status_two[INT_ALARM_INDICATION_POS])
        else $error("alarm indication rise did not set interrupt status");
    AST_LOS_SET: assert property (@(posedge clk_in) disable iff (srst_in)
        (bit_tick && !pulse_seen && quiet_full && !los_real) |=> los_real ##1
        (signal_absent_flag_out))
        else $error("quiet window did not raise signal absent");
    AST_QUIET_RESTART: assert property (@(posedge clk_in) disable iff (srst_in)
        pulse_at_tick |=> quiet_count == 13'h0000)
        else $error("pulse did not restart position counter");
    AST_LOS_HOLD: assert property (@(posedge clk_in) disable iff (srst_in)
        (los_real && !pulse_at_tick) |=> los_real)
        else $error("signal absent cleared without a pulse");
    AST_AIS_TIME: assert property (@(posedge clk_in) disable iff (srst_in)
        (time_done && time_few && frame_sync_lost_in && !criterion) ##1 !criterion
        |-> ##1 alarm_indication_flag_out)
        else $error("sparse zeros in sync loss did not raise alarm indication");
    AST_AIS_FAS: assert property (@(posedge clk_in) disable iff (srst_in)
        (frame_alignment_word_in && criterion && !emulation) ##1 (criterion && !emulation)
        |-> ##1 !alarm_indication_flag_out)
        else $error("alignment word did not clear alarm indication");
    AST_STATUS_READ: assert property (@(posedge clk_in) disable iff (srst_in)
        (take_read && take_idx == IDX_FRAMER_RECEIVE_STATUS_FIRST) |=>
        hrdata_out[STATUS_SIGNAL_ABSENT_POS] == $past(signal_absent_flag_out))
        else $error("status read does not show signal absent flag");
endmodule // line_alarm_detector

// File: line_transmitter_model.sv
// remote line transmitter model: AMI marks on two rails plus an analog level
// assumes clk_in is the bench clock; line clock finishes its current bit, then stands still while run_in is low
`timescale 1ns/1ps
module line_transmitter_model (
    // bench clock
    input wire logic clk_in,
    // bit requests
    input wire logic run_in,
    input wire logic mark_in,
    input wire logic [7:0] mark_level_in,
    // line pins
    output logic line_clock_out,
    output logic pos_rail_out,
    output logic neg_rail_out,
    output logic [7:0] level_out,
    output logic tick_out
);
    logic [2:0] phase = 3'h0;
    logic polarity = 1'b0;
    logic mark = 1'b0;
    // 4 cycles low then 4 high, so the 3-flop pin filter sees every edge
    assign line_clock_out = phase[2];
    assign tick_out = (phase == 3'h7);
    assign pos_rail_out = mark & polarity;
    assign neg_rail_out = mark & ~polarity;
    // a space shows a changing level far below any threshold, never a stale mark
    assign level_out = mark ? mark_level_in : {5'h0, phase};
    always_ff @(posedge clk_in) begin
        if (phase != 3'h0 || run_in) begin
            phase <= phase + 3'h1;
        end
        if (phase == 3'h0 && run_in) begin
            mark <= mark_in;
            polarity <= polarity ^ mark_in;
        end
    end
endmodule // line_transmitter_model

// File: line_alarm_detector_bench.sv
// self-checking bench of the receive line alarm detector
// assumes the line model above and an AHB-Lite master with zero-wait slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module line_alarm_detector_bench;
    import line_alarm_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic run = 1'b0;
    logic mark = 1'b0;
    logic [7:0] mark_level = 8'hff;
    logic sync_lost = 1'b0;
    logic align_word = 1'b0;
    logic rd_phase = 1'b0;
    wire logic line_clk, pos, neg, tick, hready, hresp, signal_absent_flag, alarm_indication_flag;
    wire logic [7:0] level;
    wire logic [31:0] hrdata;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] rnd, exp_q[$], mask_q[$], m_e, m_m;
    string name_q[$], m_n;

    line_transmitter_model u_line_transmitter_model (.clk_in(clk_in), .run_in(run),
        .mark_in(mark), .mark_level_in(mark_level), .line_clock_out(line_clk),
        .pos_rail_out(pos), .neg_rail_out(neg), .level_out(level), .tick_out(tick));
    line_alarm_detector u_line_alarm_detector (.clk_in(clk_in), .srst_in(srst_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .rx_line_clock_in(line_clk),
        .rx_pos_rail_in(pos), .rx_neg_rail_in(neg), .rx_level_in(level),
        .frame_sync_lost_in(sync_lost), .frame_alignment_word_in(align_word),
        .signal_absent_flag_out(signal_absent_flag), .alarm_indication_flag_out(alarm_indication_flag));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // bus master and line driver
    // ------------------------------------------------------------------
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] val,
                       input logic [7:0] mask, input string nm);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, val};
        rd_phase <= ~wr;
        if (!wr) begin
            exp_q.push_back(val);
            mask_q.push_back(mask);
            name_q.push_back(nm);
        end
        do @(posedge clk_in); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask

    task automatic send(input int n, input logic m, input logic [7:0] lv);
        @(posedge clk_in);
        run <= 1'b1;
        mark <= m;
        mark_level <= lv;
        repeat (n) begin
            do @(negedge clk_in); while (tick !== 1'b1);
        end
        @(posedge clk_in);
        run <= 1'b0;
    endtask

    // bounded wait; a limit of zero checks the present level only
    task automatic flag(input string nm, input logic sel, input logic v, input int lim);
        int k;
        k = 0;
        while (k < lim && (sel ? alarm_indication_flag : signal_absent_flag) !== v) begin
            @(negedge clk_in);
            k++;
        end
        `CHK(nm, v, sel ? alarm_indication_flag : signal_absent_flag)
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // read results are taken in the data phase, oldest note first
    always @(posedge clk_in) begin
        if (rd_phase && hready === 1'b1 && exp_q.size() > 0) begin
            m_e = exp_q.pop_front();
            m_m = mask_q.pop_front();
            m_n = name_q.pop_front();
            `CHK(m_n, ({24'h0, m_e}), (hrdata & {24'hffffff, m_m}))
            `CHK("response", 1'b0, hresp)
        end
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h33f8));
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        bus(IDX_FRAMER_RECEIVE_STATUS_FIRST, 0, 8'h00, 8'hff, "status");
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h00, 8'hff, "int");
        bus(8'h40, 0, 8'h00, 8'hff, "unmapped");
        rnd = 8'($urandom);
        bus(IDX_RECOVERY_PULSE_COUNT, 1, rnd, 8'h00, "");
        bus(IDX_RECOVERY_PULSE_COUNT, 0, rnd, 8'hff, "recovery count");
        bus(IDX_FRAMER_RECEIVE_STATUS_FIRST, 1, 8'hff, 8'h00, "");
        bus(IDX_FRAMER_RECEIVE_STATUS_FIRST, 0, 8'h00, 8'hff, "status ro");
        // dual rail, window 32 positions, two pulses to recover
        bus(IDX_LINE_INTERFACE_MODE_ONE, 1, 8'h01, 8'h00, "");
        bus(IDX_TRANSITION_WINDOW_COUNT, 1, 8'h01, 8'h00, "");
        bus(IDX_RECOVERY_PULSE_COUNT, 1, 8'h01, 8'h00, "");
        send(31, 0, 8'h00);
        repeat (20) @(negedge clk_in);
        flag("absent early", 0, 0, 0);
        send(1, 0, 8'h00);
        flag("absent set", 0, 1, 20);
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h01, 8'h03, "int absent");
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h00, 8'h03, "int read clear");
        bus(IDX_FRAMER_RECEIVE_STATUS_FIRST, 0, 8'h80, 8'hc0, "status absent");
        send(1, 1, 8'hff);
        send(40, 0, 8'h00);
        flag("absent one pulse", 0, 1, 0);
        send(2, 1, 8'hff);
        flag("absent recovered", 0, 0, 20);
        // analog, threshold code 2, window 16, one pulse to recover
        bus(IDX_LINE_INTERFACE_MODE_ONE, 1, 8'h20, 8'h00, "");
        bus(IDX_TRANSITION_WINDOW_COUNT, 1, 8'h00, 8'h00, "");
        bus(IDX_RECOVERY_PULSE_COUNT, 1, 8'h00, 8'h00, "");
        send(16, 1, 8'($urandom_range(8'h3d, 8'h08)));
        flag("weak marks absent", 0, 1, 20);
        send(1, 1, 8'($urandom_range(8'hff, 8'h3f)));
        flag("strong mark clears", 0, 0, 20);
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h01, 8'h01, "int absent again");
        // emulation forces both flags
        bus(IDX_FRAMER_MODE_FIRST, 1, 8'h01, 8'h00, "");
        flag("emulated absent", 0, 1, 10);
        flag("emulated indication", 1, 1, 10);
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h03, 8'h03, "int both");
        bus(IDX_FRAMER_MODE_FIRST, 1, 8'h00, 8'h00, "");
        flag("emulation off absent", 0, 0, 10);
        flag("emulation off indication", 1, 0, 2600);
        // criterion 1 sets on all-ones doubleframes although sync is held
        bus(IDX_FRAMER_MODE_FIRST, 1, 8'h02, 8'h00, "");
        send(1540, 1, 8'hff);
        flag("doubleframe indication", 1, 1, 20);
        bus(IDX_INTERRUPT_STATUS_TWO, 0, 8'h02, 8'h02, "int indication");
        @(posedge clk_in);
        align_word <= 1'b1;
        @(posedge clk_in);
        align_word <= 1'b0;
        flag("alignment clears", 1, 0, 10);
        // criterion 0 follows sync loss over the 250 us window
        bus(IDX_FRAMER_MODE_FIRST, 1, 8'h00, 8'h00, "");
        @(posedge clk_in);
        sync_lost <= 1'b1;
        flag("sync lost indication", 1, 1, 2600);
        @(posedge clk_in);
        sync_lost <= 1'b0;
        flag("sync back clears", 1, 0, 2600);
        tally_and_finish();
    end
endmodule // line_alarm_detector_bench
